// ### logic/asp_pkg.sv
// Constants, types and helpers of the four-mode asynchronous serial port.
// Assumes a single system clock and a byte-wide register port.
package asp_pkg;

  localparam logic [7:0] ADDR_CTRL = 8'h98;
  localparam logic [7:0] ADDR_DATA = 8'h99;
  localparam logic [7:0] ADDR_DIVL = 8'h9a;
  localparam logic [7:0] ADDR_DIVH = 8'h9b;

  localparam logic [7:0] DIVL_RST = 8'h9b;
  localparam logic [3:0] DIVH_RST = 4'h0;
  localparam logic [7:0] ZERO_BYTE = 8'h00;

  // Last tick index of a bit and the tick at its centre.
  localparam logic [3:0] TICK_LAST_1X = 4'hf;
  localparam logic [3:0] TICK_HALF_1X = 4'h7;
  localparam logic [3:0] TICK_LAST_2X = 4'h7;
  localparam logic [3:0] TICK_HALF_2X = 4'h3;

  localparam logic [3:0] DATA_BITS_8 = 4'h8;
  localparam logic [3:0] DATA_BITS_9 = 4'h9;
  localparam logic [3:0] BIT_FIRST = 4'h0;
  localparam logic [3:0] BIT_STEP = 4'h1;
  localparam logic [11:0] DIV_STEP = 12'h001;

  typedef enum logic [1:0] {
    ASP_MODE0 = 2'b00,
    ASP_MODE1 = 2'b01,
    ASP_MODE2 = 2'b10,
    ASP_MODE3 = 2'b11
  } asp_mode_e;

  typedef enum logic [1:0] {
    ASP_IDLE = 2'b00,
    ASP_START = 2'b01,
    ASP_DATA = 2'b11,
    ASP_STOP = 2'b10
  } asp_state_e;

  typedef struct packed {
    asp_mode_e mode;
    logic multi_station_select;
    logic rx_enable;
    logic tx_ninth_bit;
    logic rx_ninth_bit;
    logic tx_done_flag;
    logic rx_done_flag;
  } asp_ctrl_s;

  typedef struct packed {
    logic rate_double;
    logic reserved;
    logic receive_line_invert;
    logic transmit_line_invert;
    logic [3:0] div_high;
  } asp_rate_hi_s;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } asp_bus_s;

  function automatic logic [3:0] asp_tick_last(input logic dbl);
    asp_tick_last = dbl ? TICK_LAST_2X : TICK_LAST_1X;
  endfunction : asp_tick_last

  function automatic logic [3:0] asp_tick_half(input logic dbl);
    asp_tick_half = dbl ? TICK_HALF_2X : TICK_HALF_1X;
  endfunction : asp_tick_half

  // Modes 2 and 3 carry nine data bits.
  function automatic logic asp_nine(input asp_mode_e m);
    asp_nine = (m == ASP_MODE2) || (m == ASP_MODE3);
  endfunction : asp_nine

  // Modes 1 and 3 use two pins; modes 0 and 2 share the receive pin.
  function automatic logic asp_two_pin(input asp_mode_e m);
    asp_two_pin = (m == ASP_MODE1) || (m == ASP_MODE3);
  endfunction : asp_two_pin

endpackage : asp_pkg

// ### logic/asp_serial_port.sv
// Four-mode asynchronous serial port with byte-wide register port.
// Assumes software drives single-cycle strobes and that rxd_in comes
// from a pin outside the clock domain.
`timescale 1ns/100ps
`default_nettype none

module asp_serial_port (
  input wire logic clk,
  input wire logic rst,
  input wire asp_pkg::asp_bus_s bus_req,
  output logic [7:0] bus_rdata,
  input wire logic rxd_in,
  output logic rxd_out,
  output logic rxd_oe,
  output logic txd,
  output logic tx_done,
  output logic rx_done
);

  asp_pkg::asp_ctrl_s ctrl_q;
  asp_pkg::asp_rate_hi_s rate_hi_q;
  logic [7:0] div_low_q;
  logic [7:0] tx_buf_q;
  logic [7:0] rx_buf_q;
  logic tx_pending_q;
  logic [7:0] rdata_q;

  logic [11:0] div_cnt_q;
  logic tick;

  logic sync1_q;
  logic sync2_q;
  logic sync3_q;
  logic line_q;
  logic rx_line;
  logic rx_prev_q;

  asp_pkg::asp_state_e tx_state_q;
  logic [3:0] tx_tick_q;
  logic [3:0] tx_bit_q;
  logic [8:0] tx_shift_q;
  logic tx_end;
  logic tx_level;
  logic txd_q;
  logic rxd_out_q;
  logic rxd_oe_q;

  asp_pkg::asp_state_e rx_state_q;
  logic [3:0] rx_tick_q;
  logic [3:0] rx_bit_q;
  logic [8:0] rx_shift_q;
  logic rx_end;
  logic rx_accept;

  logic wr_ctrl;
  logic wr_data;
  logic nine;
  logic two_pin;
  logic [3:0] nbits;
  logic [3:0] tick_last;
  logic [3:0] tick_half;
  asp_pkg::asp_ctrl_s wr_ctrl_val;

  assign wr_ctrl = bus_req.wr && (bus_req.addr == asp_pkg::ADDR_CTRL);
  assign wr_data = bus_req.wr && (bus_req.addr == asp_pkg::ADDR_DATA);
  assign wr_ctrl_val = asp_pkg::asp_ctrl_s'(bus_req.wdata);
  assign nine = asp_pkg::asp_nine(ctrl_q.mode);
  assign two_pin = asp_pkg::asp_two_pin(ctrl_q.mode);
  assign nbits = nine ? asp_pkg::DATA_BITS_9 : asp_pkg::DATA_BITS_8;
  assign tick_last = asp_pkg::asp_tick_last(rate_hi_q.rate_double);
  assign tick_half = asp_pkg::asp_tick_half(rate_hi_q.rate_double);

  // Register writes; hardware events win over a software clear.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl_q <= asp_pkg::asp_ctrl_s'(asp_pkg::ZERO_BYTE);
    end else begin
      if (wr_ctrl) begin
        ctrl_q <= wr_ctrl_val;
      end
      if (tx_end) begin
        ctrl_q.tx_done_flag <= 1'b1;
      end
      if (rx_end) begin
        if (nine) begin
          ctrl_q.rx_ninth_bit <= rx_shift_q[8];
        end
        if (rx_accept) begin
          ctrl_q.rx_done_flag <= 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      div_low_q <= asp_pkg::DIVL_RST;
      rate_hi_q <= asp_pkg::asp_rate_hi_s'({4'h0, asp_pkg::DIVH_RST});
    end else if (bus_req.wr && bus_req.addr == asp_pkg::ADDR_DIVL) begin
      div_low_q <= bus_req.wdata;
    end else if (bus_req.wr && bus_req.addr == asp_pkg::ADDR_DIVH) begin
      rate_hi_q <= asp_pkg::asp_rate_hi_s'(bus_req.wdata);
      rate_hi_q.reserved <= 1'b0;
    end
  end

  // Transmit buffer is write-only; a write queues one frame.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tx_buf_q <= asp_pkg::ZERO_BYTE;
      tx_pending_q <= 1'b0;
    end else begin
      if (wr_data) begin
        tx_buf_q <= bus_req.wdata;
        tx_pending_q <= 1'b1;
      end else if (tx_state_q == asp_pkg::ASP_IDLE) begin
        tx_pending_q <= 1'b0;
      end
    end
  end

  // Read data stand for the one cycle after the strobe.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata_q <= asp_pkg::ZERO_BYTE;
    end else if (bus_req.rd) begin
      case (bus_req.addr)
        asp_pkg::ADDR_CTRL: begin
          rdata_q <= ctrl_q;
        end
        asp_pkg::ADDR_DATA: begin
          rdata_q <= rx_buf_q;
        end
        asp_pkg::ADDR_DIVL: begin
          rdata_q <= div_low_q;
        end
        asp_pkg::ADDR_DIVH: begin
          rdata_q <= rate_hi_q;
        end
        default: begin
          rdata_q <= asp_pkg::ZERO_BYTE;
        end
      endcase
    end else begin
      rdata_q <= asp_pkg::ZERO_BYTE;
    end
  end

  // One oversampling tick every divisor plus one clocks.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      div_cnt_q <= 12'h000;
    end else if (div_cnt_q >= {rate_hi_q.div_high, div_low_q}) begin
      div_cnt_q <= 12'h000;
    end else begin
      div_cnt_q <= div_cnt_q + asp_pkg::DIV_STEP;
    end
  end

  assign tick = (div_cnt_q >= {rate_hi_q.div_high, div_low_q});

  // Three-stage pin sampler; the line moves only when the last two stages agree.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sync1_q <= 1'b1;
      sync2_q <= 1'b1;
      sync3_q <= 1'b1;
      line_q <= 1'b1;
      rx_prev_q <= 1'b1;
    end else begin
      sync1_q <= rxd_in;
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
      if (sync2_q == sync3_q) begin
        line_q <= sync3_q;
      end
      rx_prev_q <= rx_line;
    end
  end

  assign rx_line = line_q ^ (rate_hi_q.receive_line_invert && two_pin);

  // Transmitter: start, data LSB first, stop.
  assign tx_end = (tx_state_q == asp_pkg::ASP_STOP) && tick &&
                  (tx_tick_q == tick_last);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tx_state_q <= asp_pkg::ASP_IDLE;
      tx_tick_q <= asp_pkg::BIT_FIRST;
      tx_bit_q <= asp_pkg::BIT_FIRST;
      tx_shift_q <= 9'h1ff;
    end else begin
      case (tx_state_q)
        asp_pkg::ASP_IDLE: begin
          tx_tick_q <= asp_pkg::BIT_FIRST;
          tx_bit_q <= asp_pkg::BIT_FIRST;
          if (tx_pending_q) begin
            tx_shift_q <= {ctrl_q.tx_ninth_bit, tx_buf_q};
            tx_state_q <= asp_pkg::ASP_START;
          end
        end
        asp_pkg::ASP_START: begin
          if (tick) begin
            tx_tick_q <= tx_tick_q + asp_pkg::BIT_STEP;
            if (tx_tick_q == tick_last) begin
              tx_tick_q <= asp_pkg::BIT_FIRST;
              tx_state_q <= asp_pkg::ASP_DATA;
            end
          end
        end
        asp_pkg::ASP_DATA: begin
          if (tick) begin
            tx_tick_q <= tx_tick_q + asp_pkg::BIT_STEP;
            if (tx_tick_q == tick_last) begin
              tx_tick_q <= asp_pkg::BIT_FIRST;
              tx_shift_q <= {1'b1, tx_shift_q[8:1]};
              tx_bit_q <= tx_bit_q + asp_pkg::BIT_STEP;
              if (tx_bit_q == nbits - asp_pkg::BIT_STEP) begin
                tx_state_q <= asp_pkg::ASP_STOP;
              end
            end
          end
        end
        asp_pkg::ASP_STOP: begin
          if (tick) begin
            tx_tick_q <= tx_tick_q + asp_pkg::BIT_STEP;
            if (tx_tick_q == tick_last) begin
              tx_state_q <= asp_pkg::ASP_IDLE;
            end
          end
        end
        default: begin
          tx_state_q <= asp_pkg::ASP_IDLE;
        end
      endcase
    end
  end

  always_comb begin
    case (tx_state_q)
      asp_pkg::ASP_START: begin
        tx_level = 1'b0;
      end
      asp_pkg::ASP_DATA: begin
        tx_level = tx_shift_q[0];
      end
      default: begin
        tx_level = 1'b1;
      end
    endcase
  end

  // Pin drivers; single-wire modes drive the receive pin only in a frame.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      txd_q <= 1'b1;
      rxd_out_q <= 1'b1;
      rxd_oe_q <= 1'b0;
    end else if (two_pin) begin
      txd_q <= tx_level ^ rate_hi_q.transmit_line_invert;
      rxd_out_q <= 1'b1;
      rxd_oe_q <= 1'b0;
    end else begin
      txd_q <= 1'b1;
      rxd_out_q <= tx_level;
      rxd_oe_q <= (tx_state_q != asp_pkg::ASP_IDLE);
    end
  end

  // Receiver: own echo is ignored while a single-wire frame goes out.
  assign rx_end = (rx_state_q == asp_pkg::ASP_STOP) && tick &&
                  (rx_tick_q == tick_last);
  assign rx_accept = !(nine && ctrl_q.multi_station_select) ||
                     rx_shift_q[8];

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rx_state_q <= asp_pkg::ASP_IDLE;
      rx_tick_q <= asp_pkg::BIT_FIRST;
      rx_bit_q <= asp_pkg::BIT_FIRST;
      rx_shift_q <= 9'h000;
    end else begin
      case (rx_state_q)
        asp_pkg::ASP_IDLE: begin
          rx_tick_q <= asp_pkg::BIT_FIRST;
          rx_bit_q <= asp_pkg::BIT_FIRST;
          if (ctrl_q.rx_enable && rx_prev_q && !rx_line &&
              (two_pin || tx_state_q == asp_pkg::ASP_IDLE)) begin
            rx_state_q <= asp_pkg::ASP_START;
          end
        end
        asp_pkg::ASP_START: begin
          if (tick) begin
            rx_tick_q <= rx_tick_q + asp_pkg::BIT_STEP;
            if (rx_tick_q == tick_half) begin
              rx_tick_q <= asp_pkg::BIT_FIRST;
              if (rx_line) begin
                rx_state_q <= asp_pkg::ASP_IDLE;
              end else begin
                rx_state_q <= asp_pkg::ASP_DATA;
              end
            end
          end
        end
        asp_pkg::ASP_DATA: begin
          if (tick) begin
            rx_tick_q <= rx_tick_q + asp_pkg::BIT_STEP;
            if (rx_tick_q == tick_last) begin
              rx_tick_q <= asp_pkg::BIT_FIRST;
              if (nine) begin
                rx_shift_q <= {rx_line, rx_shift_q[8:1]};
              end else begin
                rx_shift_q <= {1'b0, rx_line, rx_shift_q[7:1]};
              end
              rx_bit_q <= rx_bit_q + asp_pkg::BIT_STEP;
              if (rx_bit_q == nbits - asp_pkg::BIT_STEP) begin
                rx_state_q <= asp_pkg::ASP_STOP;
              end
            end
          end
        end
        asp_pkg::ASP_STOP: begin
          if (tick) begin
            rx_tick_q <= rx_tick_q + asp_pkg::BIT_STEP;
            if (rx_tick_q == tick_last) begin
              rx_state_q <= asp_pkg::ASP_IDLE;
            end
          end
        end
        default: begin
          rx_state_q <= asp_pkg::ASP_IDLE;
        end
      endcase
    end
  end

  // Receive buffer is read-only from software and loads at stop centre.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rx_buf_q <= asp_pkg::ZERO_BYTE;
    end else if (rx_end && rx_accept) begin
      rx_buf_q <= rx_shift_q[7:0];
    end
  end

  assign bus_rdata = rdata_q;
  assign rxd_out = rxd_out_q;
  assign rxd_oe = rxd_oe_q;
  assign txd = txd_q;
  assign tx_done = ctrl_q.tx_done_flag;
  assign rx_done = ctrl_q.rx_done_flag;

endmodule : asp_serial_port

`default_nettype wire

// ### testbench/asp_monitor.sv
// Concurrent checks on the serial port's pins and register port.
// Assumes it is bound to asp_serial_port and sees only its ports.
`timescale 1ns/100ps
`default_nettype none
module asp_monitor (
  input wire logic clk,
  input wire logic rst,
  input wire asp_pkg::asp_bus_s bus_req,
  input wire logic [7:0] bus_rdata,
  input wire logic rxd_in,
  input wire logic rxd_out,
  input wire logic rxd_oe,
  input wire logic txd,
  input wire logic tx_done,
  input wire logic rx_done
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  logic ctrl_wr;
  assign ctrl_wr = bus_req.wr && bus_req.addr == asp_pkg::ADDR_CTRL;

  // A single-wire frame opens with at least eight cycles of start bit.
  sequence s_oe_rise;
    $rose(rxd_oe);
  endsequence
  sequence s_start_low;
    (rxd_oe && !rxd_out)[*8];
  endsequence

  property p_rd_quiet;
    !$past(bus_req.rd) |-> bus_rdata == 8'h00;
  endproperty
  property p_unmapped;
    bus_req.rd && !(bus_req.addr inside {[8'h98:8'h9b]}) |=>
      bus_rdata == 8'h00;
  endproperty
  property p_oe_idle;
    !rxd_oe |-> rxd_out;
  endproperty
  property p_single_txd;
    rxd_oe |-> txd;
  endproperty
  property p_start;
    s_oe_rise |-> s_start_low;
  endproperty
  property p_stop;
    $fell(rxd_oe) |-> rxd_out && $past(rxd_out);
  endproperty
  property p_tx_set;
    ctrl_wr && bus_req.wdata[1] |=> tx_done;
  endproperty
  property p_rx_set;
    ctrl_wr && bus_req.wdata[0] |=> rx_done;
  endproperty
  property p_tx_keep;
    tx_done && !ctrl_wr |=> tx_done;
  endproperty
  property p_rx_keep;
    rx_done && !ctrl_wr |=> rx_done;
  endproperty

  a_rd_quiet: assert property (p_rd_quiet)
    else $error("read data outside its slot");
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped read not zero");
  a_oe_idle: assert property (p_oe_idle)
    else $error("shared wire level low while released");
  a_single_txd: assert property (p_single_txd)
    else $error("transmit pin moved in single wire");
  a_start: assert property (p_start)
    else $error("start bit short or high");
  a_stop: assert property (p_stop)
    else $error("frame ended without stop level");
  a_tx_set: assert property (p_tx_set)
    else $error("transmit flag not set by write");
  a_rx_set: assert property (p_rx_set)
    else $error("receive flag not set by write");
  a_tx_keep: assert property (p_tx_keep)
    else $error("transmit flag dropped");
  a_rx_keep: assert property (p_rx_keep)
    else $error("receive flag dropped");
endmodule : asp_monitor

bind asp_serial_port asp_monitor asp_monitor_i (.clk(clk), .rst(rst),
  .bus_req(bus_req), .bus_rdata(bus_rdata), .rxd_in(rxd_in),
  .rxd_out(rxd_out), .rxd_oe(rxd_oe), .txd(txd), .tx_done(tx_done),
  .rx_done(rx_done));
`default_nettype wire

// ### testbench/asp_remote.sv
// Remote serial station that sends and captures frames on the line.
// Assumes the bench routes the line level to line_in and from line_out.
`timescale 1ns/100ps
`default_nettype none
module asp_remote (
  input wire logic clk,
  input wire logic line_in,
  output logic line_out
);
  initial line_out = 1'b1;

  // Start low, data least significant bit first, stop high.
  task automatic send(input logic [8:0] d, input int n, input int bt);
    line_out <= 1'b0;
    repeat (bt) @(posedge clk);
    for (int i = 0; i < n; i++) begin
      line_out <= d[i];
      repeat (bt) @(posedge clk);
    end
    line_out <= 1'b1;
    repeat (bt) @(posedge clk);
  endtask : send

  // A missing start edge leaves all ones, which the caller sees as wrong.
  task automatic get(output logic [10:0] f, input int n, input int bt);
    int k;
    f = '0;
    k = 0;
    while (line_in !== 1'b0 && k < 4000) begin
      @(posedge clk);
      k++;
    end
    repeat (bt / 2) @(posedge clk);
    for (int i = 0; i < n + 2; i++) begin
      f[i] = line_in;
      repeat (bt) @(posedge clk);
    end
  endtask : get
endmodule : asp_remote
`default_nettype wire

// ### testbench/async_serial_port_four_mode_tb.sv
// Self-checking bench of the four-mode serial port.
// Assumes the remote station model drives and watches the line.
`timescale 1ns/100ps
`default_nettype none
module async_serial_port_four_mode_tb;
  logic clk = 1'b0;
  logic rst = 1'b1;
  asp_pkg::asp_bus_s bus_req = '0;
  logic [7:0] bus_rdata;
  logic rxd_out, rxd_oe, txd, tx_done, rx_done, rem_in, rem_out, rxd_in;
  logic single = 1'b0;
  logic tflip = 1'b0;
  logic rflip = 1'b0;
  int error_cnt = 0;
  int checks_done = 0;
  int cyc = 0;

  always #12.5 clk = ~clk;
  // The flips stand in for inverters on the far side of the line.
  assign rxd_in = rxd_oe ? rxd_out : rem_out ^ rflip;
  assign rem_in = single ? rxd_in : txd ^ tflip;

  asp_serial_port asp_serial_port_i (.clk(clk), .rst(rst),
    .bus_req(bus_req), .bus_rdata(bus_rdata), .rxd_in(rxd_in),
    .rxd_out(rxd_out), .rxd_oe(rxd_oe), .txd(txd), .tx_done(tx_done),
    .rx_done(rx_done));
  asp_remote asp_remote_i (.clk(clk), .line_in(rem_in),
    .line_out(rem_out));

  task automatic summarize();
    if (error_cnt == 0 && checks_done > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : summarize

  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      summarize();
    end
  end

  task automatic chk(input logic [10:0] g, input logic [10:0] e);
    checks_done++;
    if (g !== e) begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    bus_req <= '0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    bus_req <= '0;
    #1;
    chk({3'h0, bus_rdata}, {3'h0, e});
  endtask : rd

  task automatic t_regs();
    rd(asp_pkg::ADDR_CTRL, 8'h00);
    rd(asp_pkg::ADDR_DATA, 8'h00);
    rd(asp_pkg::ADDR_DIVL, 8'h9b);
    rd(asp_pkg::ADDR_DIVH, 8'h00);
    rd(8'h9c, 8'h00);
    wr(asp_pkg::ADDR_DIVH, 8'hff);
    rd(asp_pkg::ADDR_DIVH, 8'hbf);
    wr(asp_pkg::ADDR_DIVL, 8'h01);
    rd(asp_pkg::ADDR_DIVL, 8'h01);
  endtask : t_regs

  task automatic t_flags();
    wr(asp_pkg::ADDR_CTRL, 8'h03);
    #1;
    chk({9'h0, tx_done, rx_done}, 11'h3);
    rd(asp_pkg::ADDR_CTRL, 8'h03);
    wr(asp_pkg::ADDR_CTRL, 8'h00);
    #1;
    chk({9'h0, tx_done, rx_done}, 11'h0);
  endtask : t_flags

  task automatic t_tx(input logic [1:0] m, input logic [7:0] dh,
      input int bt);
    logic [10:0] f;
    single <= ~m[0];
    tflip <= m[0] & dh[4];
    wr(asp_pkg::ADDR_DIVH, dh);
    wr(asp_pkg::ADDR_CTRL, {m, 6'h08});
    wr(asp_pkg::ADDR_DATA, 8'h5a);
    asp_remote_i.get(f, m[1] ? 9 : 8, bt);
    chk(f, m[1] ? 11'h6b4 : 11'h2b4);
    chk({10'h0, tx_done}, 11'h1);
  endtask : t_tx

  task automatic t_rx(input logic [1:0] m, input logic [5:0] c,
      input logic [8:0] d, input logic [7:0] ed, input logic ef);
    single <= ~m[0];
    tflip <= 1'b0;
    wr(asp_pkg::ADDR_CTRL, 8'h00);
    // Flip the far-side inverter while the receiver is off, so that the
    // pin settles before the new mode applies its own inversion.
    rflip <= m[0];
    wr(asp_pkg::ADDR_DIVH, 8'h20);
    wr(asp_pkg::ADDR_CTRL, {m, c});
    asp_remote_i.send(d, m[1] ? 9 : 8, 32);
    repeat (8) @(posedge clk);
    chk({10'h0, rx_done}, {10'h0, ef});
    rd(asp_pkg::ADDR_DATA, ed);
    if (m[1])
      rd(asp_pkg::ADDR_CTRL, {m, c[5:3], d[8], 1'b0, ef});
  endtask : t_rx

  task automatic t_rx_modes();
    t_rx(2'b00, 6'h10, 9'h0c3, 8'hc3, 1'b1);
    t_rx(2'b01, 6'h10, 9'h03c, 8'h3c, 1'b1);
    t_rx(2'b10, 6'h10, 9'h1a5, 8'ha5, 1'b1);
    t_rx(2'b11, 6'h10, 9'h196, 8'h96, 1'b1);
  endtask : t_rx_modes

  task automatic t_rx_refuse();
    t_rx(2'b01, 6'h00, 9'h0f0, 8'h96, 1'b0);
    t_rx(2'b11, 6'h30, 9'h055, 8'h96, 1'b0);
    t_rx(2'b11, 6'h30, 9'h155, 8'h55, 1'b1);
  endtask : t_rx_refuse

  task automatic t_duplex();
    logic [10:0] f;
    wr(asp_pkg::ADDR_CTRL, 8'h00);
    single <= 1'b0;
    tflip <= 1'b0;
    rflip <= 1'b0;
    wr(asp_pkg::ADDR_DIVH, 8'h00);
    wr(asp_pkg::ADDR_CTRL, 8'h50);
    fork
      asp_remote_i.send(9'h0e1, 8, 32);
      begin
        wr(asp_pkg::ADDR_DATA, 8'h3c);
        asp_remote_i.get(f, 8, 32);
      end
    join
    repeat (8) @(posedge clk);
    chk(f, 11'h278);
    rd(asp_pkg::ADDR_DATA, 8'he1);
  endtask : t_duplex

  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    t_regs();
    t_flags();
    for (int m = 0; m < 4; m++) t_tx(m[1:0], 8'h10, 32);
    t_tx(2'b01, 8'h80, 16);
    t_rx_modes();
    t_rx_refuse();
    t_duplex();
    summarize();
  end
endmodule : async_serial_port_four_mode_tb
`default_nettype wire
